// ### rtl/cfg_link_pkg.sv
// Constants shared by the configuration link register bank
package cfg_link_pkg;

  // --------------------------------------------------------------------------
  // Register offsets
  // --------------------------------------------------------------------------
  localparam int unsigned ADDR_W = 15;
  localparam logic [14:0] OFS_SETUP_PRIMARY   = 15'h0000;
  localparam logic [14:0] OFS_SETUP_SECONDARY = 15'h0001;
  localparam logic [14:0] OFS_POWER_MODE      = 15'h0002;

  // --------------------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------------------
  localparam int unsigned BIT_SOFT_RESET_HIGH = 7;
  localparam int unsigned BIT_STEP_DIRECTION  = 5;
  localparam int unsigned BIT_SERIAL_OUT_ON   = 4;
  localparam int unsigned BIT_SOFT_RESET_LOW  = 0;
  localparam int unsigned BIT_ONE_COMMAND     = 7;
  localparam int unsigned BIT_SHORT_ADDRESS   = 3;
  localparam int unsigned POWER_LSB           = 0;

  // --------------------------------------------------------------------------
  // Reset values and masks
  // --------------------------------------------------------------------------
  localparam logic [7:0] RST_SETUP_PRIMARY   = 8'h10;
  localparam logic [7:0] RST_SETUP_SECONDARY = 8'h00;
  localparam logic [7:0] RST_POWER_MODE      = 8'h00;
  localparam logic [7:0] MASK_PRIMARY_RSVD   = 8'h4E;
  localparam logic [7:0] MASK_SECONDARY_RSVD = 8'h77;
  localparam logic [7:0] MASK_POWER_RSVD     = 8'hFC;
  localparam logic [7:0] READ_UNMAPPED       = 8'h00;

  // --------------------------------------------------------------------------
  // Power modes
  // --------------------------------------------------------------------------
  localparam logic [1:0] PWR_NORMAL   = 2'h0;
  localparam logic [1:0] PWR_RESERVED = 2'h1;
  localparam logic [1:0] PWR_STANDBY  = 2'h2;
  localparam logic [1:0] PWR_SLEEP    = 2'h3;

  // --------------------------------------------------------------------------
  // Serial framing
  // --------------------------------------------------------------------------
  localparam logic [3:0] LAST_BIT_BYTE  = 4'h7;
  localparam logic [3:0] LAST_BIT_LONG  = 4'hF;
  localparam logic [3:0] CNT_ZERO       = 4'h0;
  localparam logic [2:0] PIN_SYNC_RESET = 3'h2;  // sclk low, cs high, sdi low

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_INSTR = 4'b0010,
    ST_DATA  = 4'b0100,
    ST_HOLD  = 4'b1000
  } link_state_t;

endpackage

// ### rtl/cfg_link_regs.sv
// Serial configuration link target with interface and power setup registers
`timescale 1ns/1ns
`default_nettype none
module cfg_link_regs (
  // Clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst_n,
  // Serial link pins
  input  wire logic       i_sclk,
  input  wire logic       i_cs_n,
  input  wire logic       i_sdi,
  output var  logic       o_sdo,
  output var  logic       o_sdo_oe,
  // Configuration to the converter
  output var  logic       o_address_step_direction,
  output var  logic       o_one_command_mode,
  output var  logic       o_short_address,
  output var  logic [1:0] o_power_mode,
  output var  logic       o_soft_reset_pulse
);
  import cfg_link_pkg::*;

  // --------------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------------
  function automatic logic [14:0] step_addr(input logic [14:0] a, input logic up);
    step_addr = up ? 15'(a + 15'h0001) : 15'(a - 15'h0001);
  endfunction

  function automatic logic [1:0] effective_power(input logic [1:0] code);
    effective_power = (code == PWR_RESERVED) ? PWR_NORMAL : code;
  endfunction

  // --------------------------------------------------------------------------
  // Pin synchronisation and edges
  // --------------------------------------------------------------------------
  logic [2:0]  pins_sync;
  logic        sclk_s;
  logic        cs_n_s;
  logic        sdi_s;
  logic        sclk_prev_reg;
  logic        rise;
  logic        fall;

  pin_sync u_pin_sync (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_pins    ({i_sclk, i_cs_n, i_sdi}),
    .o_pins    (pins_sync)
  );

  assign sclk_s = pins_sync[2];
  assign cs_n_s = pins_sync[1];
  assign sdi_s  = pins_sync[0];
  assign rise   = sclk_s & ~sclk_prev_reg & ~cs_n_s;
  assign fall   = ~sclk_s & sclk_prev_reg & ~cs_n_s;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sclk_prev_reg <= 1'b0;
    end else begin
      sclk_prev_reg <= sclk_s;
    end
  end

  // --------------------------------------------------------------------------
  // Registers and frame state
  // --------------------------------------------------------------------------
  link_state_t state_reg;
  logic [3:0]  cnt_reg;
  logic [14:0] shift_reg;
  logic [14:0] addr_reg;
  logic        read_reg;
  logic [7:0]  tx_reg;
  logic        dir_reg;
  logic        single_reg;
  logic        short_reg;
  logic [1:0]  power_reg;

  logic [3:0]  instr_last;
  logic [15:0] instr_word;
  logic [7:0]  byte_in;
  logic        instr_done;
  logic        byte_done;
  logic        wr_stb;
  logic        soft_rst;
  logic [7:0]  rd_data;

  assign instr_last = short_reg ? LAST_BIT_BYTE : LAST_BIT_LONG;
  assign instr_word = {shift_reg, sdi_s};
  assign byte_in    = {shift_reg[6:0], sdi_s};
  assign instr_done = rise && (state_reg == ST_INSTR) && (cnt_reg == instr_last);
  assign byte_done  = rise && (state_reg == ST_DATA) && (cnt_reg == LAST_BIT_BYTE);
  assign wr_stb     = byte_done && !read_reg;
  // Both halves of the trigger must arrive in the same byte
  assign soft_rst   = wr_stb && (addr_reg == OFS_SETUP_PRIMARY)
                      && byte_in[BIT_SOFT_RESET_HIGH] && byte_in[BIT_SOFT_RESET_LOW];

  // Readback builds reserved and trigger bits as zero
  always_comb begin
    rd_data = READ_UNMAPPED;
    unique case (addr_reg)
      OFS_SETUP_PRIMARY: begin
        rd_data                     = READ_UNMAPPED;
        rd_data[BIT_STEP_DIRECTION] = dir_reg;
        rd_data[BIT_SERIAL_OUT_ON]  = 1'b1;
      end
      OFS_SETUP_SECONDARY: begin
        rd_data                    = READ_UNMAPPED;
        rd_data[BIT_ONE_COMMAND]   = single_reg;
        rd_data[BIT_SHORT_ADDRESS] = short_reg;
      end
      OFS_POWER_MODE: begin
        rd_data                       = READ_UNMAPPED;
        rd_data[POWER_LSB +: 2]       = power_reg;
      end
      default: begin
        rd_data = READ_UNMAPPED;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Frame sequencer
  // --------------------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= CNT_ZERO;
      shift_reg <= '0;
      addr_reg  <= '0;
      read_reg  <= 1'b0;
    end else if (cs_n_s) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= CNT_ZERO;
    end else if (rise) begin
      shift_reg <= instr_word[14:0];
      unique case (state_reg)
        ST_IDLE, ST_INSTR: begin
          if (instr_done) begin
            state_reg <= ST_DATA;
            cnt_reg   <= CNT_ZERO;
            read_reg  <= short_reg ? instr_word[7] : instr_word[15];
            addr_reg  <= short_reg ? {8'h00, instr_word[6:0]} : instr_word[14:0];
          end else begin
            state_reg <= ST_INSTR;
            cnt_reg   <= 4'(cnt_reg + 4'h1);
          end
        end
        ST_DATA: begin
          if (cnt_reg == LAST_BIT_BYTE) begin
            cnt_reg <= CNT_ZERO;
            if (single_reg) begin
              state_reg <= ST_HOLD;
            end else begin
              addr_reg <= step_addr(addr_reg, dir_reg);
            end
          end else begin
            cnt_reg <= 4'(cnt_reg + 4'h1);
          end
        end
        ST_HOLD: begin
          state_reg <= ST_HOLD;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dir_reg    <= RST_SETUP_PRIMARY[BIT_STEP_DIRECTION];
      single_reg <= RST_SETUP_SECONDARY[BIT_ONE_COMMAND];
      short_reg  <= RST_SETUP_SECONDARY[BIT_SHORT_ADDRESS];
      power_reg  <= RST_POWER_MODE[POWER_LSB +: 2];
    end else if (soft_rst) begin
      // Direction bit survives, so a stream keeps its sense
      dir_reg    <= dir_reg;
      single_reg <= RST_SETUP_SECONDARY[BIT_ONE_COMMAND];
      short_reg  <= RST_SETUP_SECONDARY[BIT_SHORT_ADDRESS];
      power_reg  <= RST_POWER_MODE[POWER_LSB +: 2];
    end else if (wr_stb) begin
      unique case (addr_reg)
        OFS_SETUP_PRIMARY: begin
          dir_reg <= byte_in[BIT_STEP_DIRECTION];
        end
        OFS_SETUP_SECONDARY: begin
          single_reg <= byte_in[BIT_ONE_COMMAND];
          short_reg  <= byte_in[BIT_SHORT_ADDRESS];
        end
        OFS_POWER_MODE: begin
          power_reg <= byte_in[POWER_LSB +: 2];
        end
        default: begin
          power_reg <= power_reg;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Serial output and converter controls
  // --------------------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_reg   <= '0;
      o_sdo    <= 1'b0;
      o_sdo_oe <= 1'b0;
    end else begin
      o_sdo_oe <= ~cs_n_s && (state_reg == ST_DATA) && read_reg;
      if (fall && (state_reg == ST_DATA) && read_reg) begin
        if (cnt_reg == CNT_ZERO) begin
          o_sdo  <= rd_data[7];
          tx_reg <= {rd_data[6:0], 1'b0};
        end else begin
          o_sdo  <= tx_reg[7];
          tx_reg <= {tx_reg[6:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_address_step_direction <= 1'b0;
      o_one_command_mode       <= 1'b0;
      o_short_address          <= 1'b0;
      o_power_mode             <= PWR_NORMAL;
      o_soft_reset_pulse       <= 1'b0;
    end else begin
      o_address_step_direction <= dir_reg;
      o_one_command_mode       <= single_reg;
      o_short_address          <= short_reg;
      o_power_mode             <= effective_power(power_reg);
      o_soft_reset_pulse       <= soft_rst;
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  a_soft_reset_defaults: assert property (soft_rst |=> !single_reg && !short_reg && power_reg == PWR_NORMAL)
    else $error("soft reset did not restore defaults");
  a_soft_reset_keeps_dir: assert property (soft_rst |=> dir_reg == $past(dir_reg))
    else $error("soft reset changed step direction");
  a_half_trigger_none: assert property (
      wr_stb && addr_reg == OFS_SETUP_PRIMARY &&
      (byte_in[BIT_SOFT_RESET_HIGH] ^ byte_in[BIT_SOFT_RESET_LOW]) |=> !o_soft_reset_pulse)
    else $error("soft reset fired on one trigger bit");
  a_trigger_pulse: assert property (soft_rst |=> o_soft_reset_pulse ##1 !o_soft_reset_pulse)
    else $error("soft reset pulse not one cycle");
  a_step_up_addr: assert property (
      byte_done && !single_reg && dir_reg && !cs_n_s |=> addr_reg == 15'($past(addr_reg) + 15'h0001))
    else $error("stream address did not step up");
  a_step_down_addr: assert property (
      byte_done && !single_reg && !dir_reg && !cs_n_s |=> addr_reg == 15'($past(addr_reg) - 15'h0001))
    else $error("stream address did not step down");
  a_one_command_hold: assert property (
      byte_done && single_reg && !cs_n_s |=> state_reg == ST_HOLD && $stable(addr_reg))
    else $error("one command mode kept streaming");
  a_short_instr_len: assert property (
      rise && state_reg == ST_INSTR && cnt_reg == LAST_BIT_BYTE && short_reg |=> state_reg == ST_DATA)
    else $error("short address phase not eight bits");
  a_power_output_map: assert property (
      ##1 o_power_mode == effective_power($past(power_reg)) && o_power_mode != PWR_RESERVED)
    else $error("power output does not follow field");
  a_reserved_read_zero: assert property (
      (addr_reg != OFS_SETUP_PRIMARY   || (rd_data & MASK_PRIMARY_RSVD)   == 8'h00) &&
      (addr_reg != OFS_SETUP_SECONDARY || (rd_data & MASK_SECONDARY_RSVD) == 8'h00) &&
      (addr_reg != OFS_POWER_MODE      || (rd_data & MASK_POWER_RSVD)     == 8'h00))
    else $error("reserved bit reads nonzero");

  c_soft_reset: cover property (soft_rst);
  c_stream_read: cover property (byte_done && read_reg ##[1:300] byte_done);
  c_sleep_mode: cover property (o_power_mode == PWR_SLEEP);
  c_short_write: cover property (short_reg && wr_stb);

endmodule
`default_nettype wire

// ### rtl/pin_sync.sv
// Two-stage synchroniser for the serial link pins
`timescale 1ns/1ns
`default_nettype none
module pin_sync (
  // Clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst_n,
  // Pins in, synchronised out
  input  wire logic [2:0] i_pins,
  output var  logic [2:0] o_pins
);
  import cfg_link_pkg::*;

  logic [2:0] meta_reg;

  // First stage feeds only the second
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_reg <= PIN_SYNC_RESET;
      o_pins   <= PIN_SYNC_RESET;
    end else begin
      meta_reg <= i_pins;
      o_pins   <= meta_reg;
    end
  end

endmodule
`default_nettype wire

// ### sim/cfg_host_model.sv
// Serial host controller model driving the configuration link
`timescale 1ns/1ns
`default_nettype none
module cfg_host_model (
  // Clock
  input  wire logic i_clk_sys,
  // Serial link pins
  output var  logic o_sclk,
  output var  logic o_cs_n,
  output var  logic o_sdi,
  input  wire logic i_sdo,
  input  wire logic i_sdo_oe
);
  logic oe_bad;

  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_sdi  = 1'b0;
    oe_bad = 1'b0;
  end

  // Each sclk level held 6 system clocks, above the 4 the target needs
  task automatic bit_io(input logic b, input logic rd, output logic g);
    o_sdi <= b;
    repeat (6) @(negedge i_clk_sys);
    // Undriven line shows the inverse so a missing enable cannot pass
    g = i_sdo_oe ? i_sdo : ~i_sdo;
    if (rd && i_sdo_oe !== 1'b1) oe_bad = 1'b1;
    o_sclk <= 1'b1;
    repeat (6) @(negedge i_clk_sys);
    o_sclk <= 1'b0;
  endtask

  // One frame: instruction then n bytes, MSB first, taken from wd[31] down
  task automatic xfer(input logic rd, input logic short_a, input logic [14:0] addr, input int n,
                      input logic [31:0] wd, output logic [31:0] rdat);
    logic [15:0] ins;
    logic        g;
    int          nb;
    ins  = short_a ? {rd, addr[6:0], 8'h00} : {rd, addr};
    nb   = short_a ? 8 : 16;
    rdat = 32'h0000_0000;
    @(negedge i_clk_sys);
    o_cs_n <= 1'b0;
    repeat (4) @(negedge i_clk_sys);
    for (int i = 0; i < nb; i++) begin
      bit_io(ins[15-i], 1'b0, g);
    end
    for (int i = 0; i < n * 8; i++) begin
      bit_io(wd[31-i], rd, g);
      rdat[31-i] = g;
    end
    repeat (4) @(negedge i_clk_sys);
    o_cs_n <= 1'b1;
    o_sdi  <= ~o_sdi;  // Deselected line must not hold a stale value
    repeat (8) @(negedge i_clk_sys);
  endtask
endmodule
`default_nettype wire

// ### sim/cfg_link_regs_tb_top.sv
// Testbench for the configuration link register bank
`timescale 1ns/1ns
`default_nettype none
module cfg_link_regs_tb_top;
  import cfg_link_pkg::*;
  logic        i_clk_sys;
  logic        i_rst_n;
  logic        sclk, cs_n, sdi, sdo, sdo_oe, dir, one, sh, pulse;
  logic [1:0]  pwr;
  logic        short_m;
  logic [31:0] rq;
  int          failures    = 0;
  int          check_count = 0;
  int          pulses      = 0;

  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys) if (pulse === 1'b1) pulses++;

  cfg_link_regs u_dut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_sdi(sdi), .o_sdo(sdo), .o_sdo_oe(sdo_oe), .o_address_step_direction(dir),
    .o_one_command_mode(one), .o_short_address(sh), .o_power_mode(pwr), .o_soft_reset_pulse(pulse));
  cfg_host_model u_host (.i_clk_sys(i_clk_sys), .o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi),
    .i_sdo(sdo), .i_sdo_oe(sdo_oe));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    logic [31:0] q;
    u_host.xfer(1'b0, short_m, a, 1, {d, 24'h000000}, q);
  endtask
  task automatic rd(input logic [14:0] a, input logic [7:0] exp);
    logic [31:0] q;
    u_host.xfer(1'b1, short_m, a, 1, 32'h0000_0000, q);
    chk(q[31:24], exp);
  endtask
  // Outputs packed as {dir, one command, short, power}
  task automatic outs(input logic [7:0] exp);
    chk({3'h0, dir, one, sh, pwr}, exp);
  endtask
  task automatic give_verdict;
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Whole run is well under 30k cycles
  initial begin
    #300_000;
    failures++;
    give_verdict;
  end

  initial begin
    i_rst_n = 1'b0;
    short_m = 1'b0;
    repeat (5) @(negedge i_clk_sys);
    i_rst_n <= 1'b1;
    repeat (3) @(negedge i_clk_sys);
    outs(8'h00);
    rd(OFS_SETUP_PRIMARY, RST_SETUP_PRIMARY);
    rd(OFS_SETUP_SECONDARY, 8'h00);
    rd(OFS_POWER_MODE, 8'h00);
    wr(OFS_SETUP_PRIMARY, 8'h20);
    rd(OFS_SETUP_PRIMARY, 8'h30);
    outs(8'h10);
    wr(OFS_SETUP_SECONDARY, 8'h08);
    short_m = 1'b1;
    rd(OFS_SETUP_SECONDARY, 8'h08);
    outs(8'h14);
    rd(15'h007F, READ_UNMAPPED);
    for (int c = 0; c < 4; c++) begin
      wr(OFS_POWER_MODE, c[7:0]);
      rd(OFS_POWER_MODE, c[7:0]);
      outs(8'h14 | (c == 1 ? 8'h00 : c[7:0]));
    end
    u_host.xfer(1'b0, 1'b1, OFS_SETUP_SECONDARY, 2, 32'h0802_0000, rq);
    u_host.xfer(1'b1, 1'b1, OFS_SETUP_PRIMARY, 3, 32'h0000_0000, rq);
    chk(rq[31:24], 8'h30);
    chk(rq[23:16], 8'h08);
    chk(rq[15:8], 8'h02);
    wr(OFS_SETUP_PRIMARY, 8'h00);
    u_host.xfer(1'b1, 1'b1, OFS_POWER_MODE, 3, 32'h0000_0000, rq);
    chk(rq[31:24], 8'h02);
    chk(rq[23:16], 8'h08);
    chk(rq[15:8], 8'h10);
    wr(OFS_SETUP_SECONDARY, 8'h88);
    u_host.xfer(1'b0, 1'b1, OFS_POWER_MODE, 2, 32'h0300_0000, rq);
    rd(OFS_SETUP_SECONDARY, 8'h88);
    rd(OFS_POWER_MODE, 8'h03);
    outs(8'h0F);
    chk(u_host.oe_bad ? 8'h01 : 8'h00, 8'h00);
    wr(OFS_SETUP_PRIMARY, 8'h80);
    wr(OFS_SETUP_PRIMARY, 8'h21);
    chk(pulses[7:0], 8'h00);
    rd(OFS_SETUP_SECONDARY, 8'h88);
    // Converter idle here: no conversions are clocked by this bench
    wr(OFS_SETUP_PRIMARY, 8'h81);
    short_m = 1'b0;
    chk(pulses[7:0], 8'h01);
    rd(OFS_SETUP_PRIMARY, 8'h30);
    rd(OFS_SETUP_SECONDARY, 8'h00);
    rd(OFS_POWER_MODE, 8'h00);
    outs(8'h10);
    give_verdict;
  end
endmodule
`default_nettype wire
